/* File: hw/opi_pkg.sv */
`default_nettype none
package opi_pkg;
  // widths
  localparam int SYS_BUS_W = 18;
  localparam int CMD_W = 4;
  localparam int LEVEL_W = 3;
  localparam int KEY_W = 5;
  localparam int PDATA_W = 4;
  localparam int SEL_W = 3;
  localparam int APB_AW = 8;
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int CHECK_MIN_NS = 100;
  localparam int CHECK_MIN_CYC = (CHECK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_SETUP_CYC = 1;
  localparam int STROBE_WIDTH_CYC = 1;
  localparam int STROBE_HOLD_CYC = 1;
  localparam int SCAN_DWELL_CYC = 4;
  // panel mode that enables the power key
  localparam logic [3:0] MODE_POWER_OFF = 4'h6;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_SYS_OUT = 8'h08;
  localparam logic [7:0] OFF_SYS_IN = 8'h0c;
  localparam logic [7:0] OFF_PANEL_WR = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_KEYS = 8'h18;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h1c;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h20;
  localparam logic [7:0] OFF_IRQ_EN = 8'h24;
  localparam logic [7:0] OFF_PANEL_RD = 8'h28;
  // ctrl fields
  localparam int CTRL_SYS_OE = 0;
  localparam int CTRL_LAMP = 1;
  localparam int CTRL_PWR_REQ = 2;
  localparam int CTRL_MODE_LSB = 4;
  // panel write fields
  localparam int PW_DATA_LSB = 0;
  localparam int PW_SEL_LSB = 4;
  localparam int PW_DEGATE = 7;
  // irq bits
  localparam int IRQ_W = 4;
  localparam int IRQ_CHECK = 0;
  localparam int IRQ_KEY = 1;
  localparam int IRQ_LEVEL = 2;
  localparam int IRQ_PWRKEY = 3;
  localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
endpackage : opi_pkg
`default_nettype wire

/* File: hw/opi_sync.sv */
`default_nettype none
module opi_sync #(
  parameter int W = 1
) (
  // clock
  input wire logic i_clk,
  input wire logic i_reset,
  // data
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_r;
  always_ff @(posedge i_clk) begin
    // every pin synchronised here is active low: reset to its idle high level,
    // otherwise each pin would look asserted for two cycles after reset
    if (i_reset) begin
      meta_r <= '1;
      o_sync <= '1;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule // opi_sync
`default_nettype wire

/* File: hw/opi_strobe.sv */
`default_nettype none
module opi_strobe
  import opi_pkg::*;
(
  // clock
  input wire logic i_clk,
  input wire logic i_reset,
  // request
  input wire logic i_go,
  output logic o_busy,
  // strobe: setup, pulse, hold
  output logic o_strobe
);
  typedef enum logic [1:0] {S_IDLE, S_SETUP, S_PULSE, S_HOLD} opi_stb_t;
  opi_stb_t state_r;
  logic [3:0] cnt_r;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_r <= S_IDLE;
      cnt_r <= 4'h0;
    end else begin
      case (state_r)
        S_IDLE: begin
          cnt_r <= 4'h0;
          if (i_go) state_r <= S_SETUP;
        end
        S_SETUP: begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == 4'(STROBE_SETUP_CYC - 1)) begin
            state_r <= S_PULSE;
            cnt_r <= 4'h0;
          end
        end
        S_PULSE: begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == 4'(STROBE_WIDTH_CYC - 1)) begin
            state_r <= S_HOLD;
            cnt_r <= 4'h0;
          end
        end
        S_HOLD: begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == 4'(STROBE_HOLD_CYC - 1)) state_r <= S_IDLE;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end
  assign o_busy = (state_r != S_IDLE);
  assign o_strobe = (state_r == S_PULSE);
endmodule // opi_strobe
`default_nettype wire

/* File: hw/opi_top.sv */
// How it works
// - one 18-bit two-way bus, addresses and data
// - four-line command bus starts, stops, resets
// - each command qualified by a strobe
// - 5-bit key code selects one key
// - 4-bit panel bus: display, leds, line select
// - degate makes display ignore panel data
// - lamp test lights all leds, shows 8s
// - power key in mode 6 requests power off
// - software instruction also requests power off
// - panel strobe only while data stable
// - 3-bit select picks character or led group
// - storage display only when unlocked; alter is not gated
`default_nettype none
module opi_top
  import opi_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [opi_pkg::APB_AW-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_irq,
  // processor side
  input wire logic [opi_pkg::SYS_BUS_W-1:0] i_sys_bus_n,
  output logic [opi_pkg::SYS_BUS_W-1:0] o_sys_bus_n,
  output logic o_sys_bus_oe,
  output logic [opi_pkg::CMD_W-1:0] o_processor_command_bus_n,
  output logic o_processor_command_strobe_n,
  input wire logic [opi_pkg::LEVEL_W-1:0] i_operating_level_code_n,
  input wire logic i_processor_check_cond_n,
  input wire logic i_processor_running_indication_n,
  input wire logic i_processor_check_pulse_n,
  // panel side
  output logic [opi_pkg::KEY_W-1:0] o_key_select,
  input wire logic i_key_pressed_n,
  input wire logic [opi_pkg::PDATA_W-1:0] i_panel_data_bus_n,
  output logic [opi_pkg::PDATA_W-1:0] o_panel_data_bus_n,
  output logic o_panel_data_bus_oe,
  output logic o_degate_display,
  output logic [opi_pkg::SEL_W-1:0] o_select_bus,
  output logic o_panel_strobe_n,
  output logic o_lamp_test_n,
  input wire logic i_power_key_n,
  output logic o_power_off_n,
  input wire logic i_storage_unlock_n
);
  import opi_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers; pin polarity folded to active high here
  localparam int SYNC_W = SYS_BUS_W + LEVEL_W + 5 + PDATA_W;
  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] sync_out;
  assign sync_in = {i_sys_bus_n, i_operating_level_code_n, i_processor_check_cond_n,
                    i_processor_running_indication_n, i_processor_check_pulse_n,
                    i_key_pressed_n, i_power_key_n, i_panel_data_bus_n};
  opi_sync #(.W(SYNC_W)) u_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_async(sync_in),
    .o_sync(sync_out)
  );
  logic [SYS_BUS_W-1:0] sys_in;
  logic [LEVEL_W-1:0] level;
  logic proc_check_cond;
  logic proc_running;
  logic check_pulse;
  logic key_pressed;
  logic power_key;
  logic [PDATA_W-1:0] panel_in;
  assign {sys_in, level, proc_check_cond, proc_running, check_pulse, key_pressed, power_key,
          panel_in} = ~sync_out;
  // edge detectors stay quiet until the synchronisers hold real pin values
  logic [2:0] settle_r;
  always_ff @(posedge i_clk) begin
    if (i_reset) settle_r <= 3'h0;
    else settle_r <= {settle_r[1:0], 1'b1};
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  function automatic logic hit(input logic [APB_AW-1:0] a, input logic [7:0] off);
    return a == off;
  endfunction
  logic wr_en;
  logic rd_en;
  logic mapped;
  assign wr_en = i_psel && i_penable && i_pwrite;
  assign rd_en = i_psel && i_penable && !i_pwrite;
  assign mapped = hit(i_paddr, OFF_CTRL) || hit(i_paddr, OFF_CMD) ||
                  hit(i_paddr, OFF_SYS_OUT) || hit(i_paddr, OFF_SYS_IN) ||
                  hit(i_paddr, OFF_PANEL_WR) || hit(i_paddr, OFF_STATUS) ||
                  hit(i_paddr, OFF_KEYS) || hit(i_paddr, OFF_IRQ_STAT) ||
                  hit(i_paddr, OFF_IRQ_CLR) || hit(i_paddr, OFF_IRQ_EN) ||
                  hit(i_paddr, OFF_PANEL_RD);
  // every register answers at once, so no wait states are ever inserted
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !mapped;

  ////////////////////////////////////////////////////////////////////////////
  // control register
  logic [31:0] ctrl_r;
  always_ff @(posedge i_clk) begin
    if (i_reset) ctrl_r <= RESET_ZERO;
    else if (wr_en && hit(i_paddr, OFF_CTRL)) ctrl_r <= i_pwdata;
  end
  logic [3:0] panel_mode;
  assign panel_mode = ctrl_r[CTRL_MODE_LSB +: 4];

  // system bus output, only driven when software enables it
  always_ff @(posedge i_clk) begin
    if (i_reset) o_sys_bus_n <= '1;
    else if (wr_en && hit(i_paddr, OFF_SYS_OUT)) o_sys_bus_n <= ~i_pwdata[SYS_BUS_W-1:0];
  end
  assign o_sys_bus_oe = ctrl_r[CTRL_SYS_OE];
  // storage unlock pin: own two-stage synchroniser, reset to the locked level
  logic unlock_m_r;
  logic unlock_n_s_r;
  logic unlock;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      unlock_m_r <= 1'b1;
      unlock_n_s_r <= 1'b1;
    end else begin
      unlock_m_r <= i_storage_unlock_n;
      unlock_n_s_r <= unlock_m_r;
    end
  end
  // a locked read returns zero, never stale bus contents
  assign unlock = !unlock_n_s_r;

  ////////////////////////////////////////////////////////////////////////////
  // processor command: data and strobe
  logic cmd_busy;
  logic cmd_strobe;
  logic cmd_go;
  assign cmd_go = wr_en && hit(i_paddr, OFF_CMD) && !cmd_busy;
  always_ff @(posedge i_clk) begin
    if (i_reset) o_processor_command_bus_n <= '1;
    else if (cmd_go) o_processor_command_bus_n <= ~i_pwdata[CMD_W-1:0];
  end
  opi_strobe u_cmd_stb (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_go(cmd_go),
    .o_busy(cmd_busy),
    .o_strobe(cmd_strobe)
  );
  assign o_processor_command_strobe_n = ~cmd_strobe;

  ////////////////////////////////////////////////////////////////////////////
  // panel writes: data, select, degate held through the strobe
  logic pnl_busy;
  logic pnl_strobe;
  logic pnl_go;
  logic [PDATA_W-1:0] pnl_data_r;
  assign pnl_go = wr_en && hit(i_paddr, OFF_PANEL_WR) && !pnl_busy;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pnl_data_r <= '0;
      o_select_bus <= '0;
      o_degate_display <= 1'b0;
    end else if (pnl_go) begin
      pnl_data_r <= i_pwdata[PW_DATA_LSB +: PDATA_W];
      o_select_bus <= i_pwdata[PW_SEL_LSB +: SEL_W];
      o_degate_display <= i_pwdata[PW_DEGATE];
    end
  end
  opi_strobe u_pnl_stb (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_go(pnl_go),
    .o_busy(pnl_busy),
    .o_strobe(pnl_strobe)
  );
  // bus is driven only during a write sequence, otherwise read back from panel
  assign o_panel_data_bus_n = ~pnl_data_r;
  assign o_panel_data_bus_oe = pnl_busy;
  assign o_panel_strobe_n = ~pnl_strobe;
  assign o_lamp_test_n = ~ctrl_r[CTRL_LAMP];
  // the synchronisers still carry our own drive for two cycles after release
  logic [1:0] pnl_busy_d_r;
  always_ff @(posedge i_clk) begin
    if (i_reset) pnl_busy_d_r <= 2'h0;
    else pnl_busy_d_r <= {pnl_busy_d_r[0], pnl_busy};
  end
  logic [PDATA_W-1:0] line_sel_r;
  always_ff @(posedge i_clk) begin
    if (i_reset) line_sel_r <= '0;
    else if (!pnl_busy && pnl_busy_d_r == 2'h0) line_sel_r <= panel_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // key scan: step through all codes, keep pressed map
  logic [KEY_W-1:0] key_sel_r;
  logic [2:0] dwell_r;
  logic [31:0] key_map_r;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      key_sel_r <= '0;
      dwell_r <= '0;
    end else if (dwell_r == 3'(SCAN_DWELL_CYC - 1)) begin
      dwell_r <= '0;
      key_sel_r <= key_sel_r + 5'h01;
    end else begin
      dwell_r <= dwell_r + 3'h1;
    end
  end
  assign o_key_select = key_sel_r;
  // sample late in the dwell so the synchronised answer belongs to this code
  always_ff @(posedge i_clk) begin
    if (i_reset) key_map_r <= RESET_ZERO;
    else if (dwell_r == 3'(SCAN_DWELL_CYC - 1)) key_map_r[key_sel_r] <= key_pressed;
  end
  logic key_new;
  assign key_new = (dwell_r == 3'(SCAN_DWELL_CYC - 1)) && key_pressed && !key_map_r[key_sel_r];

  ////////////////////////////////////////////////////////////////////////////
  // power off
  logic pwr_key_d_r;
  logic pwr_latch_r;
  always_ff @(posedge i_clk) begin
    if (i_reset) pwr_key_d_r <= 1'b0;
    else pwr_key_d_r <= power_key;
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) pwr_latch_r <= 1'b0;
    else if (power_key && panel_mode == MODE_POWER_OFF) pwr_latch_r <= 1'b1;
  end
  assign o_power_off_n = ~(pwr_latch_r || ctrl_r[CTRL_PWR_REQ]);

  ////////////////////////////////////////////////////////////////////////////
  // check capture and level change
  logic check_d_r;
  logic [LEVEL_W-1:0] level_d_r;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      check_d_r <= 1'b0;
      level_d_r <= '0;
    end else begin
      check_d_r <= check_pulse;
      level_d_r <= level;
    end
  end
  logic [IRQ_W-1:0] ev;
  always_comb begin
    ev = '0;
    if (settle_r[2]) begin
      ev[IRQ_CHECK] = check_pulse && !check_d_r;
      ev[IRQ_KEY] = key_new;
      ev[IRQ_LEVEL] = level != level_d_r;
      ev[IRQ_PWRKEY] = power_key && !pwr_key_d_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: set wins over clear
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_en_r;
  logic [IRQ_W-1:0] irq_clr;
  assign irq_clr = (wr_en && hit(i_paddr, OFF_IRQ_CLR)) ? i_pwdata[IRQ_W-1:0] : '0;
  always_ff @(posedge i_clk) begin
    if (i_reset) irq_stat_r <= '0;
    else irq_stat_r <= (irq_stat_r & ~irq_clr) | ev;
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) irq_en_r <= '0;
    else if (wr_en && hit(i_paddr, OFF_IRQ_EN)) irq_en_r <= i_pwdata[IRQ_W-1:0];
  end
  assign o_irq = |(irq_stat_r & irq_en_r);

  ////////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb begin
    o_prdata = '0;
    if (rd_en) begin
      case (i_paddr)
        OFF_CTRL: o_prdata = ctrl_r;
        OFF_SYS_IN: o_prdata = unlock ? {14'h0000, sys_in} : '0;
        OFF_STATUS: o_prdata = {24'h000000, unlock, cmd_busy, pnl_busy, proc_check_cond,
                                proc_running, level};
        OFF_KEYS: o_prdata = key_map_r;
        OFF_IRQ_STAT: o_prdata = {28'h0000000, irq_stat_r};
        OFF_IRQ_EN: o_prdata = {28'h0000000, irq_en_r};
        OFF_PANEL_RD: o_prdata = {28'h0000000, line_sel_r};
        default: o_prdata = '0;
      endcase
    end
  end
endmodule // opi_top
`default_nettype wire

/* File: testbench/opi_top_properties.sv */
`default_nettype none
module opi_top_properties (
  // clock, reset and apb
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [opi_pkg::APB_AW-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  // processor and panel
  input wire logic [opi_pkg::CMD_W-1:0] o_processor_command_bus_n,
  input wire logic o_processor_command_strobe_n,
  input wire logic [opi_pkg::KEY_W-1:0] o_key_select,
  input wire logic [opi_pkg::PDATA_W-1:0] o_panel_data_bus_n,
  input wire logic o_panel_data_bus_oe,
  input wire logic o_degate_display,
  input wire logic [opi_pkg::SEL_W-1:0] o_select_bus,
  input wire logic o_panel_strobe_n,
  input wire logic o_lamp_test_n,
  input wire logic i_power_key_n,
  input wire logic o_power_off_n,
  input wire logic i_storage_unlock_n
);
  import opi_pkg::*;
  logic acc_wr;
  logic acc_rd;
  logic [7:0] ctrl_r;
  assign acc_wr = i_psel && i_penable && i_pwrite;
  assign acc_rd = i_psel && i_penable && !i_pwrite;
  // mirror of the control word, since power-off legality hangs on the mode
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ctrl_r <= 8'h00;
    end else if (acc_wr && i_paddr == OFF_CTRL) begin
      ctrl_r <= i_pwdata[7:0];
    end
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  //////////////////////////////////////////////////////////////////////////////
  a_pstrobe_single: assert property ($fell(o_panel_strobe_n) |=> o_panel_strobe_n)
    else $error("panel strobe longer than one cycle");
  a_pstrobe_steady: assert property (!o_panel_strobe_n |-> o_panel_data_bus_oe &&
    $stable(o_panel_data_bus_n) && $stable(o_select_bus) && $stable(o_degate_display))
    else $error("panel lines moved under strobe");
  a_panel_load: assert property (acc_wr && i_paddr == OFF_PANEL_WR && !o_panel_data_bus_oe |=>
    o_panel_data_bus_oe && o_select_bus == $past(i_pwdata[6:4])
    && o_degate_display == $past(i_pwdata[7]) && o_panel_data_bus_n == ~$past(i_pwdata[3:0])
    ##[1:2] !o_panel_strobe_n)
    else $error("panel write not presented");
  a_cmd_issue: assert property (acc_wr && i_paddr == OFF_CMD |->
    ##[1:3] !o_processor_command_strobe_n)
    else $error("command not strobed");
  a_cmd_single: assert property ($fell(o_processor_command_strobe_n) |=>
    o_processor_command_strobe_n) else $error("command strobe too long");
  a_cmd_steady: assert property (!o_processor_command_strobe_n ||
    $rose(o_processor_command_strobe_n) |-> $stable(o_processor_command_bus_n))
    else $error("command bus moved near strobe");
  a_key_dwell: assert property ($changed(o_key_select) |->
    o_key_select == $past(o_key_select) + 5'h01 ##1 $stable(o_key_select) [*3])
    else $error("key scan step wrong");
  a_lamp_ctrl: assert property (acc_wr && i_paddr == OFF_CTRL |=>
    o_lamp_test_n == !$past(i_pwdata[1])) else $error("lamp test not following control");
  a_pwr_request: assert property (acc_wr && i_paddr == OFF_CTRL && i_pwdata[2] |=>
    !o_power_off_n) else $error("software power off missing");
  a_pwr_key: assert property (!i_power_key_n && ctrl_r[7:4] == MODE_POWER_OFF |->
    ##[1:4] !o_power_off_n) else $error("power key ignored in power-off mode");
  a_pwr_quiet: assert property (o_power_off_n && !ctrl_r[2] && !acc_wr &&
    ctrl_r[7:4] != MODE_POWER_OFF |=> o_power_off_n) else $error("spurious power off");
  a_unlock_gate: assert property (acc_rd && i_paddr == OFF_SYS_IN && i_storage_unlock_n &&
    $past(i_storage_unlock_n, 2) |-> o_prdata == RESET_ZERO) else $error("locked read leaked");
  c_degate: cover property (!o_panel_strobe_n && o_degate_display);
  c_command: cover property (!o_processor_command_strobe_n);
  c_power: cover property (!o_power_off_n);
endmodule // opi_top_properties
bind opi_top opi_top_properties opi_top_properties_i (.*);
`default_nettype wire

/* File: testbench/opi_panel_model.sv */
`default_nettype none
module opi_panel_model (
  // scan and strobe inputs
  input wire logic i_clk,
  input wire logic [opi_pkg::KEY_W-1:0] i_key_select,
  input wire logic [opi_pkg::KEY_W-1:0] i_held_key,
  input wire logic i_key_down,
  input wire logic [opi_pkg::PDATA_W-1:0] i_line_sel,
  input wire logic [opi_pkg::PDATA_W-1:0] i_dout_n,
  input wire logic i_oe,
  input wire logic i_strobe_n,
  input wire logic i_degate,
  input wire logic [opi_pkg::SEL_W-1:0] i_select,
  // answers
  output logic o_key_pressed_n,
  output logic [opi_pkg::PDATA_W-1:0] o_bus_n
);
  import opi_pkg::*;
  logic [3:0] disp [4];
  // the panel drives line select whenever the card has let go of the bus
  assign o_bus_n = i_oe ? i_dout_n : ~i_line_sel;
  assign o_key_pressed_n = !(i_key_down && i_key_select == i_held_key);
  always @(posedge i_clk) begin
    if (!i_strobe_n && !i_degate && i_select < 3'h4) begin
      disp[i_select[1:0]] <= ~o_bus_n;
    end
  end
endmodule // opi_panel_model
`default_nettype wire

/* File: testbench/testbench.sv */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import opi_pkg::*;
  logic i_clk, i_reset, i_psel, i_penable, i_pwrite, o_pready, o_pslverr, o_irq;
  logic [7:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, v;
  logic [SYS_BUS_W-1:0] i_sys_bus_n, o_sys_bus_n, sys_drv_n;
  logic [CMD_W-1:0] o_processor_command_bus_n;
  logic [LEVEL_W-1:0] i_operating_level_code_n;
  logic [KEY_W-1:0] o_key_select, held_key;
  logic [PDATA_W-1:0] i_panel_data_bus_n, o_panel_data_bus_n, line_sel;
  logic [SEL_W-1:0] o_select_bus;
  logic o_sys_bus_oe, o_processor_command_strobe_n, i_processor_check_cond_n, key_down;
  logic i_processor_running_indication_n, i_processor_check_pulse_n, i_key_pressed_n;
  logic o_panel_data_bus_oe, o_degate_display, o_panel_strobe_n, o_lamp_test_n;
  logic i_power_key_n, o_power_off_n, i_storage_unlock_n;
  logic [32:0] notes [$];
  int mismatches, comparisons, seed, n;
  assign i_sys_bus_n = o_sys_bus_oe ? o_sys_bus_n : sys_drv_n;
  opi_top opi_top_i (.*);
  opi_panel_model opi_panel_model_i (.i_clk(i_clk), .i_key_select(o_key_select),
    .i_held_key(held_key), .i_key_down(key_down), .i_line_sel(line_sel),
    .i_dout_n(o_panel_data_bus_n), .i_oe(o_panel_data_bus_oe), .i_strobe_n(o_panel_strobe_n),
    .i_degate(o_degate_display), .i_select(o_select_bus), .o_key_pressed_n(i_key_pressed_n),
    .o_bus_n(i_panel_data_bus_n));
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    i_penable <= 1'b0;
    @(posedge i_clk);
    i_penable <= 1'b1;
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (o_pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      mismatches++;
      close_out();
    end
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    notes.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  // read results are judged where they appear, against the oldest note
  always @(posedge i_clk) begin
    if (i_psel && i_penable && !i_pwrite && o_pready === 1'b1) begin
      chk({o_pslverr, o_prdata}, notes.size() > 0 ? notes.pop_front() : 33'h1_dead_beef);
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 44;
    {i_reset, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = {1'b1, 43'h0};
    sys_drv_n = 18'($random(seed));
    i_operating_level_code_n = 3'($random(seed));
    {i_processor_check_cond_n, i_processor_running_indication_n} = 2'b10;
    {i_processor_check_pulse_n, i_power_key_n, i_storage_unlock_n, key_down} = 4'he;
    held_key = 5'($random(seed));
    line_sel = 4'($random(seed));
    repeat (3) @(posedge i_clk);
    i_reset <= 1'b0;
    rd(OFF_CTRL, 33'h0);
    rd(OFF_IRQ_EN, 33'h0);
    rd(8'h3c, 33'h1_0000_0000);
    @(negedge i_clk) chk(o_power_off_n, 33'h1);
    rd(OFF_STATUS, {25'h0, 5'h01, ~i_operating_level_code_n});
    $display("test reset and status done");
    v = $random(seed);
    bus(1'b1, OFF_SYS_OUT, {14'h0, v[17:0]});
    bus(1'b1, OFF_CTRL, 32'h1);
    @(negedge i_clk) chk({o_sys_bus_oe, o_sys_bus_n}, {1'b1, 18'(~v[17:0])});
    bus(1'b1, OFF_CTRL, 32'h0);
    i_storage_unlock_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    rd(OFF_SYS_IN, 18'(~sys_drv_n));
    i_storage_unlock_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    rd(OFF_SYS_IN, 33'h0);
    $display("test system bus done");
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, OFF_CMD, 32'h1 << c);
      for (n = 0; n < 10 && o_processor_command_strobe_n !== 1'b0; n++) @(negedge i_clk);
      chk(o_processor_command_strobe_n, 33'h0);
      chk(o_processor_command_bus_n, 4'(~(4'h1 << c)));
      repeat (3) @(posedge i_clk);
    end
    $display("test commands done");
    for (int s = 0; s < 5; s++) begin
      v = $random(seed);
      bus(1'b1, OFF_PANEL_WR, {24'h0, s == 4, 3'(s % 4), v[3:0]});
      repeat (5) @(posedge i_clk);
      chk(opi_panel_model_i.disp[s % 4], s == 4 ? n : v[3:0]);
      if (s == 0) n = v[3:0];
    end
    bus(1'b1, OFF_CTRL, 32'h2);
    @(negedge i_clk) chk(o_lamp_test_n, 33'h0);
    rd(OFF_PANEL_RD, line_sel);
    $display("test panel done");
    key_down <= 1'b1;
    repeat (260) @(posedge i_clk);
    rd(OFF_KEYS, 32'h1 << held_key);
    bus(1'b1, OFF_IRQ_CLR, 32'hf);
    bus(1'b1, OFF_IRQ_EN, 32'h1);
    i_processor_check_pulse_n <= 1'b0;
    @(posedge i_clk);
    i_processor_check_pulse_n <= 1'b1;
    repeat (5) @(posedge i_clk);
    @(negedge i_clk) chk(o_irq, 33'h1);
    bus(1'b1, OFF_IRQ_EN, 32'h0);
    @(negedge i_clk) chk(o_irq, 33'h0);
    rd(OFF_IRQ_STAT, 33'h1);
    bus(1'b1, OFF_IRQ_EN, 32'h1);
    bus(1'b1, OFF_IRQ_CLR, 32'h1);
    @(negedge i_clk) chk(o_irq, 33'h0);
    rd(OFF_IRQ_STAT, 33'h0);
    $display("test keys and interrupts done");
    bus(1'b1, OFF_CTRL, 32'h4);
    @(negedge i_clk) chk(o_power_off_n, 33'h0);
    bus(1'b1, OFF_CTRL, 32'h0);
    i_power_key_n <= 1'b0;
    bus(1'b1, OFF_CTRL, 32'h50);
    repeat (5) @(posedge i_clk);
    @(negedge i_clk) chk(o_power_off_n, 33'h1);
    bus(1'b1, OFF_CTRL, 32'h60);
    repeat (5) @(posedge i_clk);
    @(negedge i_clk) chk(o_power_off_n, 33'h0);
    $display("test power done");
    close_out();
  end
endmodule // testbench
`default_nettype wire
